// ---- core/perf_event_pkg.sv ----
// Package with event codes, unit-mask fields and carrier types.
package perf_event_pkg;

    // Event numbers decoded by the selector.
    localparam logic [7:0] EV_SECOND_LEVEL_INSTR_FETCHES      = 8'h28;
    localparam logic [7:0] EV_L2_READ        = 8'h29;
    localparam logic [7:0] EV_L2_WRITE       = 8'h2A;
    localparam logic [7:0] EV_L2_REQUEST     = 8'h2E;
    localparam logic [7:0] EV_L2_REJECT      = 8'h30;
    localparam logic [7:0] EV_L2_IDLE        = 8'h32;
    localparam logic [7:0] EV_THERMAL        = 8'h3B;
    localparam logic [7:0] EV_UNHALTED       = 8'h3C;
    localparam logic [7:0] EV_L1_READ        = 8'h40;
    localparam logic [7:0] EV_L1_WRITE       = 8'h41;
    localparam logic [7:0] EV_L1_LOCK        = 8'h42;
    localparam logic [7:0] EV_L1_REF_ANY     = 8'h43;
    localparam logic [7:0] EV_L1_REF_CACHE   = 8'h44;
    localparam logic [7:0] EV_L1_REPL        = 8'h45;
    localparam logic [7:0] EV_MOD_ALLOC      = 8'h46;
    localparam logic [7:0] EV_MOD_EVICT      = 8'h47;
    localparam logic [7:0] EV_PEND_MISS      = 8'h48;
    localparam logic [7:0] EV_DTLB_MISS      = 8'h49;
    localparam logic [7:0] EV_FULL_MISS      = 8'h4B;
    localparam logic [7:0] EV_FIRST_LEVEL_PREFETCH_REQUESTS    = 8'h4F;
    localparam logic [7:0] EV_BUS_RD_OUT     = 8'h60;
    localparam logic [7:0] EV_BNR            = 8'h61;
    localparam logic [7:0] EV_DATA_READY_STROBE           = 8'h62;
    localparam logic [7:0] EV_BUS_LOCK       = 8'h63;
    localparam logic [7:0] EV_DATA_RCV       = 8'h64;
    localparam logic [7:0] EV_BURST_RD       = 8'h65;

    // Unit-mask values that some events require.
    localparam logic [7:0] UM_00             = 8'h00;
    localparam logic [7:0] UM_01             = 8'h01;
    localparam logic [7:0] UM_02             = 8'h02;
    localparam logic [7:0] UM_03             = 8'h03;
    localparam logic [7:0] UM_40             = 8'h40;

    // Unit-mask field positions.
    localparam int UM_STATE_LSB   = 0;
    localparam int UM_DEMAND_BIT  = 4;
    localparam int UM_PREF_BIT    = 5;
    localparam int UM_THIS_BIT    = 6;
    localparam int UM_OTHER_BIT   = 7;

    // Line-state encoding; the unit-mask bit index equals the code.
    localparam logic [1:0] LS_INVALID = 2'h0;

    // Width of the per-cycle event count and reset values.
    localparam int DW = 8;
    localparam logic [DW-1:0] DELTA_ZERO = 8'h00;

    // One qualified cache event for this cycle.
    typedef struct packed {
        logic       valid;
        logic       other_core;
        logic [1:0] line_state;
        logic       prefetch;
    } qual_evt_t;

    // Counter selection as programmed by software.
    typedef struct packed {
        logic       enable;
        logic       edge_mode;
        logic [7:0] event_num;
        logic [7:0] unit_mask;
        logic [7:0] counter_mask;
    } evt_sel_t;

    // All event sources, sampled once per core clock.
    typedef struct packed {
        qual_evt_t  second_level_instr_fetches;
        qual_evt_t  second_level_reads;
        qual_evt_t  second_level_writes;
        qual_evt_t  second_level_requests;
        logic       second_level_busy_reject_cycles;
        logic       second_level_idle_cycles;
        logic       thermal_trip;
        logic       unhalted_reference_cycles;
        logic       other_core_halted;
        qual_evt_t  first_level_cacheable_reads;
        qual_evt_t  first_level_cacheable_writes;
        qual_evt_t  first_level_locked_reads;
        logic       first_level_ref_any;
        logic       first_level_ref_cacheable;
        logic       first_level_line_replacements;
        logic       modified_line_allocations;
        logic       modified_line_evictions;
        logic [3:0] outstanding_miss_weight;
        logic       dtlb_miss;
        logic [3:0] full_miss_kind;
        logic       first_level_prefetch_requests;
        logic [3:0] bus_rd_outstanding_demand;
        logic [3:0] bus_rd_outstanding_prefetch;
        logic       block_next_request;
        logic       data_ready_strobe;
        logic       bus_lock;
        logic       bus_lock_other_core;
        logic       data_chunk_rcv;
        logic       burst_read;
        logic       burst_read_other_core;
    } evt_src_t;

endpackage

// ---- core/perf_event_select_decoder.sv ----
// Event-selection decoder and counter for performance monitoring.
module perf_event_select_decoder
    import perf_event_pkg::*;
#(
    parameter int CNT_W = 40
) (
    // Clock and reset.
    input  wire logic                      clk_i,
    input  wire logic                      resetn_i,
    // Software selection.
    input  wire perf_event_pkg::evt_sel_t  sel_i,
    // Event sources.
    input  wire perf_event_pkg::evt_src_t  src_i,
    // Counter and status.
    output logic [CNT_W-1:0]               count_o,
    output logic                           cond_o,
    output logic                           known_o
);
    import perf_event_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] count;
        logic             cond;
        logic             known;
    } state_t;

    state_t state_r;
    state_t state_nxt;

    logic [DW-1:0] delta;
    logic          known;
    logic          cond;
    logic          inc;
    logic [7:0]    um;

    // A zero core field selects this core only, so a single-core part
    // that writes zeros still counts its own traffic.
    function automatic logic core_ok(input logic other,
                                     input logic [7:0] m);
        core_ok = other ? m[UM_OTHER_BIT]
                        : (m[UM_THIS_BIT] | ~m[UM_OTHER_BIT]);
    endfunction

    // Both prefetch bits clear means demand and prefetch are counted.
    function automatic logic pf_ok(input logic pf, input logic [7:0] m);
        logic none;
        none  = ~m[UM_PREF_BIT] & ~m[UM_DEMAND_BIT];
        pf_ok = none | (pf ? m[UM_PREF_BIT] : m[UM_DEMAND_BIT]);
    endfunction

    // Line state, core and optionally prefetch qualification of one event.
    function automatic logic qual_hit(input qual_evt_t e,
                                      input logic [7:0] m,
                                      input logic use_pf);
        logic st;
        st = m[UM_STATE_LSB + int'(e.line_state)];
        qual_hit = e.valid & st & core_ok(e.other_core, m)
                 & (~use_pf | pf_ok(e.prefetch, m));
    endfunction

    assign um = sel_i.unit_mask;

    // Event decoder: per-cycle count of the selected source.
    always_comb begin
        delta = DELTA_ZERO;
        known = 1'b1;
        case (sel_i.event_num)
            EV_SECOND_LEVEL_INSTR_FETCHES:
                delta = DW'(qual_hit(src_i.second_level_instr_fetches,
                                     um, 1'b0));
            EV_L2_READ:
                delta = DW'(qual_hit(src_i.second_level_reads,
                                     um, 1'b0));
            EV_L2_WRITE:
                delta = DW'(qual_hit(src_i.second_level_writes,
                                     um, 1'b0));
            EV_L2_REQUEST:
                delta = DW'(qual_hit(src_i.second_level_requests,
                                     um, 1'b1));
            EV_L2_REJECT:
                delta = DW'(src_i.second_level_busy_reject_cycles);
            EV_L2_IDLE:
                delta = DW'(src_i.second_level_idle_cycles);
            EV_THERMAL:
                delta = DW'(src_i.thermal_trip);
            EV_UNHALTED: begin
                if (um == UM_01) begin
                    delta = DW'(src_i.unhalted_reference_cycles);
                end else if (um == UM_02) begin
                    delta = DW'(src_i.unhalted_reference_cycles
                                & src_i.other_core_halted);
                end
            end
            EV_L1_READ:
                delta = DW'(qual_hit(src_i.first_level_cacheable_reads,
                                     um, 1'b0));
            EV_L1_WRITE:
                delta = DW'(qual_hit(src_i.first_level_cacheable_writes,
                                     um, 1'b0));
            EV_L1_LOCK:
                delta = DW'(qual_hit(src_i.first_level_locked_reads, um,
                                     1'b0)
                            & (src_i.first_level_locked_reads.line_state
                               == LS_INVALID));
            EV_L1_REF_ANY: begin
                if (um == UM_01) begin
                    delta = DW'(src_i.first_level_ref_any);
                end
            end
            EV_L1_REF_CACHE: begin
                if (um == UM_02) begin
                    delta = DW'(src_i.first_level_ref_cacheable);
                end
            end
            EV_L1_REPL:
                delta = DW'(src_i.first_level_line_replacements);
            EV_MOD_ALLOC: begin
                if (um == UM_00) begin
                    delta = DW'(src_i.modified_line_allocations);
                end
            end
            EV_MOD_EVICT: begin
                if (um == UM_00) begin
                    delta = DW'(src_i.modified_line_evictions);
                end
            end
            EV_PEND_MISS:
                delta = DW'(src_i.outstanding_miss_weight);
            EV_DTLB_MISS:
                delta = DW'(src_i.dtlb_miss);
            EV_FULL_MISS: begin
                if (um <= UM_03) begin
                    delta = DW'(src_i.full_miss_kind[um[1:0]]);
                end
            end
            EV_FIRST_LEVEL_PREFETCH_REQUESTS:
                delta = DW'(src_i.first_level_prefetch_requests);
            EV_BUS_RD_OUT: begin
                // Prefetch bits pick demand, prefetcher, or both.
                if (pf_ok(1'b0, um)) begin
                    delta = DW'(src_i.bus_rd_outstanding_demand);
                end
                if (pf_ok(1'b1, um)) begin
                    delta = delta
                          + DW'(src_i.bus_rd_outstanding_prefetch);
                end
            end
            EV_BNR:
                delta = DW'(src_i.block_next_request);
            EV_DATA_READY_STROBE:
                delta = DW'(src_i.data_ready_strobe);
            EV_BUS_LOCK:
                delta = DW'(src_i.bus_lock
                            & core_ok(src_i.bus_lock_other_core,
                                      um));
            EV_DATA_RCV: begin
                if (um == UM_40) begin
                    delta = DW'(src_i.data_chunk_rcv);
                end
            end
            EV_BURST_RD:
                delta = DW'(src_i.burst_read
                            & core_ok(src_i.burst_read_other_core,
                                      um));
            default: begin
                known = 1'b0;
            end
        endcase
    end

    // Threshold and edge qualification. Edge mode without a counter mask
    // uses "any event this cycle", which is what counts trip occurrences.
    always_comb begin
        if (sel_i.counter_mask != DELTA_ZERO) begin
            cond = (delta >= sel_i.counter_mask);
        end else begin
            cond = (delta != DELTA_ZERO);
        end
        if (sel_i.edge_mode) begin
            inc = cond & ~state_r.cond;
        end else begin
            inc = cond;
        end
    end

    // Next state: the edge history tracks the condition even while the
    // counter is disabled, so re-enabling cannot fake a rising edge later.
    always_comb begin
        state_nxt       = state_r;
        state_nxt.cond  = cond;
        state_nxt.known = known;
        if (sel_i.enable && known) begin
            if (sel_i.counter_mask != DELTA_ZERO || sel_i.edge_mode) begin
                state_nxt.count = state_r.count + CNT_W'(inc);
            end else begin
                state_nxt.count = state_r.count + CNT_W'(delta);
            end
        end
    end

    // State register, cleared with the core.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign count_o = state_r.count;
    assign cond_o  = state_r.cond;
    assign known_o = state_r.known;

    // Assertions.
    sequence plain_sel(logic [7:0] ev);
        sel_i.enable && !sel_i.edge_mode
        && sel_i.counter_mask == 8'h00 && sel_i.event_num == ev;
    endsequence

    sequence trip_rise;
        !src_i.thermal_trip ##1 (src_i.thermal_trip && sel_i.enable
        && sel_i.edge_mode && sel_i.counter_mask == 8'h00
        && sel_i.event_num == 8'h3B);
    endsequence

    AST_UNKNOWN_HOLDS: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        !known |=> count_o == $past(count_o) && !known_o)
        else $error("Unlisted event changed the counter.");

    AST_DISABLED_HOLDS: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        !sel_i.enable [*2] |=> count_o == $past(count_o))
        else $error("Disabled counter moved.");

    AST_REJECT_ADDS_ONE: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        plain_sel(8'h30) and src_i.second_level_busy_reject_cycles
        |=> count_o == $past(count_o) + 1)
        else $error("Reject cycle not counted once.");

    AST_IDLE_GAP: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        plain_sel(8'h32) and !src_i.second_level_idle_cycles
        |=> count_o == $past(count_o))
        else $error("Idle event counted a busy cycle.");

    AST_TRIP_EDGE: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        trip_rise |=> count_o == $past(count_o) + 1)
        else $error("Thermal trip occurrence not counted.");

    AST_TRIP_LEVEL_EDGE: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (src_i.thermal_trip && sel_i.edge_mode) [*2]
        |=> count_o == $past(count_o))
        else $error("Held thermal trip counted twice in edge mode.");

    AST_SERIAL_NEEDS_HALT: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        plain_sel(8'h3C) and sel_i.unit_mask == 8'h02
        && !src_i.other_core_halted |=> count_o == $past(count_o))
        else $error("Serial cycles counted with other core running.");

    AST_MOD_MASK_ZERO: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        sel_i.event_num == 8'h46 && sel_i.unit_mask != 8'h00
        |=> count_o == $past(count_o))
        else $error("Modified allocation counted with wrong mask.");

    AST_MISS_WEIGHT: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        plain_sel(8'h48)
        |=> count_o == $past(count_o)
                       + $past(src_i.outstanding_miss_weight))
        else $error("Outstanding miss weight not added.");

    AST_MISS_DURATION: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        sel_i.enable && !sel_i.edge_mode && sel_i.event_num == 8'h48
        && sel_i.counter_mask == 8'h01
        && src_i.outstanding_miss_weight > 4'h1
        |=> count_o == $past(count_o) + 1)
        else $error("Counter mask did not yield duration.");

    AST_BNR_COUNT: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        plain_sel(8'h61) and src_i.block_next_request
        |=> count_o == $past(count_o) + 1)
        else $error("Block-next-request cycle not counted.");

endmodule

// ---- tb/src_model.sv ----
// Behavioural model of the cache, translation and bus event sources.
module src_model
    import perf_event_pkg::*;
(
    // Stimulus selection from the bench.
    input  wire logic [4:0]          kind_i,
    input  wire logic                on_i,
    input  wire logic                oc_i,
    input  wire logic [1:0]          ls_i,
    // Event sources seen by the decoder.
    output perf_event_pkg::evt_src_t src_o
);
    timeunit 1ns;
    timeprecision 1ns;

    qual_evt_t  q;
    logic [3:0] w;

    // Only the chosen source is active; every other one stays quiet, so a
    // decoder that picks the wrong source sees nothing and the count holds.
    always_comb begin
        q = '{valid: on_i, other_core: oc_i, line_state: ls_i,
              prefetch: 1'h0};
        w = on_i ? 4'h3 : 4'h0;
        src_o = '0;
        case (kind_i)
            5'h00: src_o.second_level_instr_fetches = q;
            5'h01: src_o.second_level_reads = q;
            5'h02: src_o.second_level_writes = q;
            5'h03: src_o.second_level_requests = q;
            5'h04: src_o.second_level_busy_reject_cycles = on_i;
            5'h05: src_o.second_level_idle_cycles = on_i;
            5'h06: src_o.thermal_trip = on_i;
            5'h07: begin
                src_o.unhalted_reference_cycles = on_i;
                src_o.other_core_halted = oc_i;
            end
            5'h08: src_o.first_level_cacheable_reads = q;
            5'h09: src_o.first_level_cacheable_writes = q;
            5'h0A: src_o.first_level_locked_reads = q;
            5'h0B: src_o.first_level_ref_any = on_i;
            5'h0C: src_o.first_level_ref_cacheable = on_i;
            5'h0D: src_o.first_level_line_replacements = on_i;
            5'h0E: src_o.modified_line_allocations = on_i;
            5'h0F: src_o.modified_line_evictions = on_i;
            5'h10: src_o.outstanding_miss_weight = w;
            5'h11: src_o.dtlb_miss = on_i;
            5'h12: src_o.full_miss_kind[ls_i] = on_i;
            5'h13: src_o.first_level_prefetch_requests = on_i;
            5'h14: src_o.bus_rd_outstanding_demand = w;
            5'h15: src_o.block_next_request = on_i;
            5'h16: src_o.data_ready_strobe = on_i;
            5'h17: begin
                src_o.bus_lock = on_i;
                src_o.bus_lock_other_core = oc_i;
            end
            5'h18: src_o.data_chunk_rcv = on_i;
            5'h19: begin
                src_o.burst_read = on_i;
                src_o.burst_read_other_core = oc_i;
            end
            default: src_o = '0;
        endcase
    end
endmodule

// ---- tb/tb_perf_event_select_decoder.sv ----
// Self-checking bench for the event-selection decoder and its counter.
module tb_perf_event_select_decoder;
    // Time units come first in the body; the package import follows them.
    timeunit 1ns;
    timeprecision 1ns;
    import perf_event_pkg::*;

    localparam int CNT_W = 40;

    typedef struct packed {
        logic [7:0] ev;
        logic [7:0] um;
        logic [7:0] cm;
        logic [4:0] kind;
        logic       oc;
        logic [1:0] ls;
        logic [3:0] exp;
    } row_t;

    // Core-select bits stay zero in every row except rows[36], whose 8'h40 mask sets bit 6.
    row_t rows [0:43] = '{
        '{8'h28, 8'h0F, 8'h00, 5'h00, 1'h0, 2'h2, 4'h1},
        '{8'h28, 8'h0B, 8'h00, 5'h00, 1'h0, 2'h2, 4'h0},
        '{8'h29, 8'h0F, 8'h00, 5'h01, 1'h1, 2'h1, 4'h0},
        '{8'h2A, 8'h08, 8'h00, 5'h02, 1'h0, 2'h3, 4'h1},
        '{8'h2E, 8'h0F, 8'h00, 5'h03, 1'h0, 2'h0, 4'h1},
        '{8'h30, 8'h00, 8'h00, 5'h04, 1'h0, 2'h0, 4'h1},
        '{8'h32, 8'h00, 8'h00, 5'h05, 1'h0, 2'h0, 4'h1},
        '{8'h3B, 8'h00, 8'h00, 5'h06, 1'h0, 2'h0, 4'h1},
        '{8'h3C, 8'h01, 8'h00, 5'h07, 1'h0, 2'h0, 4'h1},
        '{8'h3C, 8'h02, 8'h00, 5'h07, 1'h0, 2'h0, 4'h0},
        '{8'h3C, 8'h02, 8'h00, 5'h07, 1'h1, 2'h0, 4'h1},
        '{8'h40, 8'h0F, 8'h00, 5'h08, 1'h0, 2'h1, 4'h1},
        '{8'h41, 8'h0F, 8'h00, 5'h09, 1'h0, 2'h3, 4'h1},
        '{8'h42, 8'h0F, 8'h00, 5'h0A, 1'h0, 2'h0, 4'h1},
        '{8'h42, 8'h0F, 8'h00, 5'h0A, 1'h0, 2'h2, 4'h0},
        '{8'h43, 8'h01, 8'h00, 5'h0B, 1'h0, 2'h0, 4'h1},
        '{8'h43, 8'h02, 8'h00, 5'h0B, 1'h0, 2'h0, 4'h0},
        '{8'h44, 8'h02, 8'h00, 5'h0C, 1'h0, 2'h0, 4'h1},
        '{8'h45, 8'h00, 8'h00, 5'h0D, 1'h0, 2'h0, 4'h1},
        '{8'h46, 8'h00, 8'h00, 5'h0E, 1'h0, 2'h0, 4'h1},
        '{8'h47, 8'h00, 8'h00, 5'h0F, 1'h0, 2'h0, 4'h1},
        '{8'h47, 8'h01, 8'h00, 5'h0F, 1'h0, 2'h0, 4'h0},
        '{8'h48, 8'h00, 8'h00, 5'h10, 1'h0, 2'h0, 4'h3},
        '{8'h48, 8'h00, 8'h01, 5'h10, 1'h0, 2'h0, 4'h1},
        '{8'h49, 8'h00, 8'h00, 5'h11, 1'h0, 2'h0, 4'h1},
        '{8'h4B, 8'h00, 8'h00, 5'h12, 1'h0, 2'h0, 4'h1},
        '{8'h4B, 8'h01, 8'h00, 5'h12, 1'h0, 2'h1, 4'h1},
        '{8'h4B, 8'h02, 8'h00, 5'h12, 1'h0, 2'h2, 4'h1},
        '{8'h4B, 8'h03, 8'h00, 5'h12, 1'h0, 2'h3, 4'h1},
        '{8'h4B, 8'h01, 8'h00, 5'h12, 1'h0, 2'h2, 4'h0},
        '{8'h4F, 8'h00, 8'h00, 5'h13, 1'h0, 2'h0, 4'h1},
        '{8'h60, 8'h00, 8'h00, 5'h14, 1'h0, 2'h0, 4'h3},
        '{8'h60, 8'h00, 8'h01, 5'h14, 1'h0, 2'h0, 4'h1},
        '{8'h61, 8'h00, 8'h00, 5'h15, 1'h0, 2'h0, 4'h1},
        '{8'h62, 8'h00, 8'h00, 5'h16, 1'h0, 2'h0, 4'h1},
        '{8'h63, 8'h00, 8'h00, 5'h17, 1'h1, 2'h0, 4'h0},
        '{8'h64, 8'h40, 8'h00, 5'h18, 1'h0, 2'h0, 4'h1},
        '{8'h64, 8'h00, 8'h00, 5'h18, 1'h0, 2'h0, 4'h0},
        '{8'h65, 8'h00, 8'h00, 5'h19, 1'h0, 2'h0, 4'h1},
        '{8'h65, 8'h00, 8'h00, 5'h19, 1'h1, 2'h0, 4'h0},
        '{8'h50, 8'h00, 8'h00, 5'h15, 1'h0, 2'h0, 4'h0},
        '{8'h48, 8'h00, 8'h04, 5'h10, 1'h0, 2'h0, 4'h0},
        '{8'h63, 8'h00, 8'h00, 5'h17, 1'h0, 2'h0, 4'h1},
        '{8'h46, 8'h01, 8'h00, 5'h0E, 1'h0, 2'h0, 4'h0}
    };

    logic             clk_i = 1'h0;
    logic             resetn_i = 1'h0;
    evt_sel_t         sel = '0;
    evt_src_t         src;
    logic [4:0]       kind = 5'h00;
    logic             on_v = 1'h0;
    logic             oc = 1'h0;
    logic [1:0]       ls = 2'h0;
    logic [CNT_W-1:0] count_o;
    logic             cond_o;
    logic             known_o;
    logic [CNT_W-1:0] base;
    int               err_total = 0;
    int               total_checks = 0;

    // A 25 MHz core clock.
    always #20 clk_i = ~clk_i;

    src_model i_src_model (
        .kind_i (kind),
        .on_i   (on_v),
        .oc_i   (oc),
        .ls_i   (ls),
        .src_o  (src)
    );

    perf_event_select_decoder #(.CNT_W(CNT_W)) i_perf_event_select_decoder (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .sel_i    (sel),
        .src_i    (src),
        .count_o  (count_o),
        .cond_o   (cond_o),
        .known_o  (known_o)
    );

    // Compares one observed value with its expectation.
    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    // Applies one selection and source setting; called at a falling edge.
    task automatic drive(input row_t r, input logic on, input logic en,
                         input logic edg);
        sel = '{enable: en, edge_mode: edg, event_num: r.ev,
                unit_mask: r.um, counter_mask: r.cm};
        kind = r.kind;
        oc = r.oc;
        ls = r.ls;
        on_v = on;
    endtask

    task automatic give_verdict();
        $display("Checks made %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Cuts a hung run short well after the roughly 166 cycles it needs.
    initial begin
        #80000;
        err_total++;
        give_verdict();
    end

    // Reset, the table of ordinary cases, then the awkward ones.
    initial begin
        repeat (20) @(negedge clk_i);
        check("count_rst", {24'h0, count_o}, 64'h0);
        check("known_rst", {63'h0, known_o}, 64'h0);
        check("cond_rst", {63'h0, cond_o}, 64'h0);
        resetn_i = 1'h1;
        foreach (rows[i]) begin
            drive(rows[i], 1'h1, 1'h1, 1'h0);
            base = count_o;
            repeat (3) @(negedge clk_i);
            check("count", {24'h0, count_o},
                  {24'h0, base} + {60'h0, rows[i].exp} * 64'h3);
            check("known", {63'h0, known_o},
                  {63'h0, rows[i].ev != 8'h50});
            // Every active source meets its threshold whenever it counts.
            check("cond", {63'h0, cond_o},
                  {63'h0, rows[i].exp != 4'h0});
        end
        // A disabled counter holds even with its source active.
        drive(rows[33], 1'h1, 1'h0, 1'h0);
        base = count_o;
        repeat (3) @(negedge clk_i);
        check("count_off", {24'h0, count_o}, {24'h0, base});
        // The edge history follows the source even while disabled.
        check("cond_off", {63'h0, cond_o}, 64'h1);
        // Edge mode counts two trip occurrences, not trip cycles.
        drive(rows[7], 1'h0, 1'h1, 1'h1);
        repeat (2) @(negedge clk_i);
        base = count_o;
        on_v = 1'h1;
        repeat (3) @(negedge clk_i);
        on_v = 1'h0;
        @(negedge clk_i);
        on_v = 1'h1;
        repeat (2) @(negedge clk_i);
        check("count_edge", {24'h0, count_o},
              {24'h0, base} + 64'h2);
        // Reset in mid-run clears the counter, which then counts again.
        resetn_i = 1'h0;
        @(negedge clk_i);
        check("count_rst2", {24'h0, count_o}, 64'h0);
        check("known_rst2", {63'h0, known_o}, 64'h0);
        resetn_i = 1'h1;
        drive(rows[33], 1'h1, 1'h1, 1'h0);
        repeat (2) @(negedge clk_i);
        check("count_again", {24'h0, count_o}, 64'h2);
        give_verdict();
    end
endmodule
